/* ulsi_pkg.sv */
// shared constants, field layouts and state types of the serial line block
package ulsi_pkg;
  // bus address layout: word index in bits 4..2, upper bits must be zero
  localparam int unsigned ULSI_AW = 8;
  localparam int unsigned ADDR_HI_LSB = 5;
  localparam int unsigned IDX_MSB = 4;
  localparam int unsigned IDX_LSB = 2;
  // register word indexes, byte address is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_IER = 3'h1;
  localparam logic [2:0] IDX_IIR = 3'h2;
  localparam logic [2:0] IDX_LCR = 3'h3;
  localparam logic [2:0] IDX_LSR = 3'h5;
  localparam logic [2:0] IDX_MSR = 3'h6;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef struct packed {
    logic divisor_access_select;
    logic brk;
    logic stick;
    logic eps;
    logic pen;
    logic stb;
    logic [1:0] wls;
  } ulsi_lcr_t;
  typedef struct packed {
    logic [3:0] rsvd;
    logic modem;
    logic line;
    logic transmit_holding_empty;
    logic rda;
  } ulsi_ier_t;
  localparam logic [2:0] IID_NONE = 3'h1;
  localparam logic [2:0] IID_LINE = 3'h6;
  localparam logic [2:0] IID_RDA = 3'h4;
  localparam logic [2:0] IID_TRANSMIT_HOLDING_EMPTY = 3'h2;
  localparam logic [2:0] IID_MODEM = 3'h0;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] IER_MASK = 8'h0F;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [15:0] BAUD_ONE = 16'h0001;
  localparam logic [4:0] PIN_IDLE = 5'h1F;
  localparam logic [3:0] MODEM_IDLE = 4'hF;
  localparam logic [1:0] WLS_FIVE = 2'h0;
  localparam logic [3:0] CHAR_MIN_BITS = 4'h5;
  localparam logic [3:0] CHAR_MAX_BITS = 4'h8;
  // 16x oversampling counts
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [4:0] STOP_ONE = 5'h0F;
  localparam logic [4:0] STOP_ONE_HALF = 5'h17;
  localparam logic [4:0] STOP_TWO = 5'h1F;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulsi_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} ulsi_rx_t;
endpackage : ulsi_pkg

/* ulsi_uart.sv */
// serial line element: frame format, line status, interrupt identity, axi4-lite registers
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ulsi_uart (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite write channels
  input wire logic [ulsi_pkg::ULSI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ulsi_pkg::ULSI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial line and modem inputs, active low pins
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  // interrupt request, active high level
  output logic irq
);
  import ulsi_pkg::*;

  function automatic logic is_reg(input logic [ULSI_AW-1:0] a, input logic [2:0] idx);
    is_reg = (a[ULSI_AW-1:ADDR_HI_LSB] == '0) && (a[IDX_MSB:IDX_LSB] == idx);
  endfunction : is_reg

  function automatic logic [3:0] char_len(input logic [1:0] wls);
    char_len = CHAR_MIN_BITS + {2'h0, wls};
  endfunction : char_len

  function automatic logic par_bit(input ulsi_lcr_t l, input logic [7:0] d);
    logic [7:0] m;
    m = d & (8'hFF >> (CHAR_MAX_BITS - char_len(l.wls)));
    if (l.stick) begin
      par_bit = ~l.eps;
    end else begin
      par_bit = l.eps ? ^m : ~^m;
    end
  endfunction : par_bit

  function automatic logic [2:0] iid_of(input ulsi_ier_t e, input logic lp, input logic dp, input logic tp,
                                        input logic mp);
    if (e.line & lp) iid_of = IID_LINE;
    else if (e.rda & dp) iid_of = IID_RDA;
    else if (e.transmit_holding_empty & tp) iid_of = IID_TRANSMIT_HOLDING_EMPTY;
    else if (e.modem & mp) iid_of = IID_MODEM;
    else iid_of = IID_NONE;
  endfunction : iid_of

  // pin synchronisers
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic rx_in, cts_s, dsr_s, ri_s, dcd_s;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_r <= PIN_IDLE;
      sync2_r <= PIN_IDLE;
    end else begin
      sync1_r <= {serial_rx_pin, cts_n, dsr_n, ri_n, dcd_n};
      sync2_r <= sync1_r;
    end
  end
  assign {rx_in, cts_s, dsr_s, ri_s, dcd_s} = sync2_r;

  // registers and state
  ulsi_lcr_t lcr_r;
  ulsi_ier_t ier_r;
  logic [15:0] div_r, baud_cnt_r;
  logic [7:0] rbr_r, thr_r, tsr_r, rx_shift_r;
  logic dr_r, oe_r, pe_r, fe_r, bi_r, transmit_holding_empty_r, transmit_holding_empty_irq_r, irq_r, tx_line_r, tx_pin_r, tx_par_r;
  logic [3:0] mdelta_r, mprev_r;
  logic aw_hold_r, w_hold_r, w_en_r, bvalid_r, rvalid_r;
  logic [ULSI_AW-1:0] aw_addr_r;
  logic [7:0] w_byte_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;
  ulsi_tx_t tx_state_r;
  ulsi_rx_t rx_state_r;
  logic [4:0] tx_cnt_r;
  logic [2:0] tx_bit_r, rx_bit_r;
  logic [3:0] rx_cnt_r;
  logic rx_par_r, rx_stop_r, rx_brk_r, rx_done_r;

  // bus decode
  logic do_wr, wr_mapped, wr_ok, wr_thr, wr_dll, wr_ier, wr_dlm, wr_lcr;
  logic ar_fire, ar_mapped, rd_rbr, rd_iir, rd_lsr, rd_msr;
  logic [7:0] rd_word, lsr_w, msr_w;
  logic [15:0] div_nxt;
  ulsi_ier_t ier_w;
  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready = ~w_hold_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_mapped = aw_addr_r[ULSI_AW-1:ADDR_HI_LSB] == '0;
  assign wr_ok = do_wr & w_en_r;
  // divisor access bit steers the two shared words
  assign wr_thr = wr_ok & is_reg(aw_addr_r, IDX_DATA) & ~lcr_r.divisor_access_select;
  assign wr_dll = wr_ok & is_reg(aw_addr_r, IDX_DATA) & lcr_r.divisor_access_select;
  assign wr_ier = wr_ok & is_reg(aw_addr_r, IDX_IER) & ~lcr_r.divisor_access_select;
  assign wr_dlm = wr_ok & is_reg(aw_addr_r, IDX_IER) & lcr_r.divisor_access_select;
  assign wr_lcr = wr_ok & is_reg(aw_addr_r, IDX_LCR);
  // line status writes are dropped: the register is read-only here
  assign ier_w = ulsi_ier_t'(w_byte_r & IER_MASK);
  assign div_nxt = wr_dll ? {div_r[15:8], w_byte_r} : {w_byte_r, div_r[7:0]};
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign ar_mapped = s_axi_araddr[ULSI_AW-1:ADDR_HI_LSB] == '0;
  assign rd_rbr = ar_fire & is_reg(s_axi_araddr, IDX_DATA) & ~lcr_r.divisor_access_select;
  assign rd_iir = ar_fire & is_reg(s_axi_araddr, IDX_IIR);
  assign rd_lsr = ar_fire & is_reg(s_axi_araddr, IDX_LSR);
  assign rd_msr = ar_fire & is_reg(s_axi_araddr, IDX_MSR);

  // interrupt sources
  logic line_p, modem_p, tx_xfer;
  logic [2:0] iid_w;
  logic [3:0] mcur, mdelta_set;
  assign line_p = oe_r | pe_r | fe_r | bi_r;
  assign modem_p = |mdelta_r;
  assign iid_w = iid_of(ier_r, line_p, dr_r, transmit_holding_empty_irq_r, modem_p);
  assign mcur = {dcd_s, ri_s, dsr_s, cts_s};
  // ring reports only its trailing edge, the pin going high
  assign mdelta_set = {dcd_s ^ mprev_r[3], ri_s & ~mprev_r[2], dsr_s ^ mprev_r[1], cts_s ^ mprev_r[0]};
  assign lsr_w = {1'b0, transmit_holding_empty_r & (tx_state_r == TX_IDLE), transmit_holding_empty_r, bi_r, fe_r, pe_r, oe_r, dr_r};
  assign msr_w = {~mcur, mdelta_r};
  assign rd_word = is_reg(s_axi_araddr, IDX_DATA) ? (lcr_r.divisor_access_select ? div_r[7:0] : rbr_r) :
                   is_reg(s_axi_araddr, IDX_IER) ? (lcr_r.divisor_access_select ? div_r[15:8] : ier_r) :
                   is_reg(s_axi_araddr, IDX_IIR) ? {5'h00, iid_w} :
                   is_reg(s_axi_araddr, IDX_LCR) ? lcr_r :
                   is_reg(s_axi_araddr, IDX_LSR) ? lsr_w :
                   is_reg(s_axi_araddr, IDX_MSR) ? msr_w : 8'h00;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = {24'h000000, rdata_r};
  assign serial_tx_pin = tx_pin_r;
  assign irq = irq_r;

  // axi4-lite slave: address and data taken in either order, written once both are held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_byte_r <= 8'h00;
      w_en_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= AXI_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_byte_r <= s_axi_wdata[7:0];
        w_en_r <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_hold_r <= 1'b0;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= ar_mapped ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // control registers and 16x baud tick
  logic baud_tick;
  assign baud_tick = (div_r != DIV_RST) && (baud_cnt_r <= BAUD_ONE);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lcr_r <= ulsi_lcr_t'(LCR_RST);
      ier_r <= ulsi_ier_t'(IER_MASK & LCR_RST);
      div_r <= DIV_RST;
      baud_cnt_r <= DIV_RST;
    end else begin
      if (wr_lcr) lcr_r <= ulsi_lcr_t'(w_byte_r);
      if (wr_ier) ier_r <= ier_w;
      if (wr_dll | wr_dlm) div_r <= div_nxt;
      // reload on a divisor write avoids a long first count
      if (wr_dll | wr_dlm) baud_cnt_r <= div_nxt;
      else if (baud_tick) baud_cnt_r <= div_r;
      else if (baud_cnt_r != DIV_RST) baud_cnt_r <= baud_cnt_r - BAUD_ONE;
    end
  end

  // transmitter
  logic [4:0] stop_last;
  assign tx_xfer = (tx_state_r == TX_IDLE) & ~transmit_holding_empty_r;
  assign stop_last = ~lcr_r.stb ? STOP_ONE : (lcr_r.wls == WLS_FIVE ? STOP_ONE_HALF : STOP_TWO);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_state_r <= TX_IDLE;
      tx_cnt_r <= '0;
      tx_bit_r <= '0;
      tsr_r <= 8'h00;
      tx_par_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else begin
      unique case (tx_state_r)
        TX_IDLE: if (tx_xfer) begin
          tsr_r <= thr_r;
          tx_par_r <= par_bit(lcr_r, thr_r);
          tx_cnt_r <= '0;
          tx_line_r <= 1'b0;
          tx_state_r <= TX_START;
        end
        TX_START: if (baud_tick) begin
          tx_cnt_r <= tx_cnt_r + 5'h01;
          if (tx_cnt_r == STOP_ONE) begin
            tx_cnt_r <= '0;
            tx_bit_r <= '0;
            tx_line_r <= tsr_r[0];
            tx_state_r <= TX_DATA;
          end
        end
        TX_DATA: if (baud_tick) begin
          tx_cnt_r <= tx_cnt_r + 5'h01;
          if (tx_cnt_r == STOP_ONE) begin
            tx_cnt_r <= '0;
            if (tx_bit_r == 3'(char_len(lcr_r.wls) - 4'h1)) begin
              tx_line_r <= lcr_r.pen ? tx_par_r : 1'b1;
              tx_state_r <= lcr_r.pen ? TX_PAR : TX_STOP;
            end else begin
              tx_bit_r <= tx_bit_r + 3'h1;
              tsr_r <= tsr_r >> 1;
              tx_line_r <= tsr_r[1];
            end
          end
        end
        TX_PAR: if (baud_tick) begin
          tx_cnt_r <= tx_cnt_r + 5'h01;
          if (tx_cnt_r == STOP_ONE) begin
            tx_cnt_r <= '0;
            tx_line_r <= 1'b1;
            tx_state_r <= TX_STOP;
          end
        end
        TX_STOP: if (baud_tick) begin
          tx_cnt_r <= tx_cnt_r + 5'h01;
          if (tx_cnt_r == stop_last) tx_state_r <= TX_IDLE;
        end
      endcase
    end
  end

  // holding register, empty flag and its interrupt; a holding write beats a same-cycle transfer, a new set beats an identity-read clear
  logic transmit_holding_empty_irq_set, transmit_holding_empty_irq_clr;
  assign transmit_holding_empty_irq_set = (tx_xfer & ~wr_thr) | (wr_ier & ier_w.transmit_holding_empty & ~ier_r.transmit_holding_empty & transmit_holding_empty_r);
  assign transmit_holding_empty_irq_clr = wr_thr | (rd_iir & (iid_w == IID_TRANSMIT_HOLDING_EMPTY));
  always_ff @(posedge core_clk) begin
    if (rst) begin
      thr_r <= 8'h00;
      transmit_holding_empty_r <= 1'b1;
      transmit_holding_empty_irq_r <= 1'b0;
      tx_pin_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      if (wr_thr) thr_r <= w_byte_r;
      transmit_holding_empty_r <= wr_thr ? 1'b0 : (tx_xfer ? 1'b1 : transmit_holding_empty_r);
      transmit_holding_empty_irq_r <= transmit_holding_empty_irq_set | (transmit_holding_empty_irq_r & ~transmit_holding_empty_irq_clr);
      // break only overrides the pin, the shifter keeps running
      tx_pin_r <= lcr_r.brk ? 1'b0 : tx_line_r;
      irq_r <= iid_w != IID_NONE;
    end
  end

  // receiver, sampling mid-bit on the 16x tick
  logic rx_last;
  assign rx_last = rx_bit_r == 3'(char_len(lcr_r.wls) - 4'h1);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_bit_r <= '0;
      rx_shift_r <= 8'h00;
      rx_par_r <= 1'b0;
      rx_stop_r <= 1'b1;
      rx_brk_r <= 1'b0;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      unique case (rx_state_r)
        RX_IDLE: if (~rx_in) begin
          rx_cnt_r <= '0;
          rx_shift_r <= 8'h00;
          rx_par_r <= 1'b0;
          rx_state_r <= RX_START;
        end
        RX_START: if (baud_tick) begin
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_cnt_r == TICK_MID) begin
            rx_cnt_r <= '0;
            rx_bit_r <= '0;
            // a start bit gone high at mid-bit was noise
            rx_state_r <= rx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (baud_tick) begin
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_cnt_r == TICK_LAST) begin
            rx_cnt_r <= '0;
            rx_shift_r <= {rx_in, rx_shift_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_last) rx_state_r <= lcr_r.pen ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (baud_tick) begin
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_cnt_r == TICK_LAST) begin
            rx_cnt_r <= '0;
            rx_par_r <= rx_in;
            rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: if (baud_tick) begin
          rx_cnt_r <= rx_cnt_r + 4'h1;
          // only the first stop bit is looked at
          if (rx_cnt_r == TICK_LAST) begin
            rx_stop_r <= rx_in;
            rx_brk_r <= ~rx_in & (rx_shift_r == 8'h00) & ~rx_par_r;
            rx_done_r <= 1'b1;
            rx_state_r <= (~rx_in & (rx_shift_r == 8'h00) & ~rx_par_r) ? RX_BRK : RX_IDLE;
          end
        end
        RX_BRK: if (rx_in) rx_state_r <= RX_IDLE;
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // receive buffer and line status flags; a new event beats a same-cycle clear
  logic [7:0] rx_char;
  logic rx_pe;
  assign rx_char = rx_shift_r >> (CHAR_MAX_BITS - char_len(lcr_r.wls));
  assign rx_pe = lcr_r.pen & (rx_par_r != par_bit(lcr_r, rx_char));
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rbr_r <= 8'h00;
      dr_r <= 1'b0;
      oe_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      bi_r <= 1'b0;
      mdelta_r <= '0;
      mprev_r <= MODEM_IDLE;
    end else begin
      if (rx_done_r) rbr_r <= rx_char;
      dr_r <= rx_done_r | (dr_r & ~rd_rbr);
      oe_r <= (rx_done_r & dr_r & ~rd_rbr) | (oe_r & ~rd_lsr);
      pe_r <= (rx_done_r & rx_pe) | (pe_r & ~rd_lsr);
      fe_r <= (rx_done_r & ~rx_stop_r) | (fe_r & ~rd_lsr);
      bi_r <= (rx_done_r & rx_brk_r) | (bi_r & ~rd_lsr);
      mprev_r <= mcur;
      mdelta_r <= mdelta_set | (mdelta_r & ~{4{rd_msr}});
    end
  end

  a_iid_none: assert property (@(posedge core_clk) disable iff (rst)
    !(ier_r.rda & dr_r) && !(ier_r.line & line_p) && !(ier_r.transmit_holding_empty & transmit_holding_empty_irq_r) && !(ier_r.modem & modem_p)
    |-> iid_w == IID_NONE) else $error("identity not none while nothing pending");
  a_line_first: assert property (@(posedge core_clk) disable iff (rst)
    ier_r.line && (oe_r || pe_r || fe_r || bi_r) |-> iid_w == IID_LINE) else $error("line status not reported first");
  a_lsr_clear: assert property (@(posedge core_clk) disable iff (rst)
    rd_lsr && !rx_done_r |=> !(oe_r || pe_r || fe_r || bi_r)) else $error("error flags survive status read");
  a_rbr_clear: assert property (@(posedge core_clk) disable iff (rst)
    rd_rbr && !rx_done_r |=> !dr_r && iid_w != IID_RDA) else $error("data ready survives buffer read");
  a_thr_clear: assert property (@(posedge core_clk) disable iff (rst)
    wr_thr |=> !transmit_holding_empty_r && !transmit_holding_empty_irq_r) else $error("holding empty survives holding write");
  a_modem_clear: assert property (@(posedge core_clk) disable iff (rst)
    rd_msr && mdelta_set == 4'h0 |=> mdelta_r == 4'h0) else $error("modem deltas survive status read");
  a_break_out: assert property (@(posedge core_clk) disable iff (rst)
    lcr_r.brk |=> !serial_tx_pin) else $error("break did not hold output low");
  a_overrun_set: assert property (@(posedge core_clk) disable iff (rst)
    rx_done_r && dr_r && !rd_rbr |=> oe_r && dr_r) else $error("overrun not flagged");
  a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
    $rose(dr_r) && ier_r.rda && $stable(ier_r) |=> irq) else $error("interrupt output missed pending source");
  a_tx_parity: assert property (@(posedge core_clk) disable iff (rst)
    tx_state_r == TX_PAR && lcr_r.stick && $stable(lcr_r) |-> tx_line_r == ~lcr_r.eps)
    else $error("stick parity level wrong");
endmodule : ulsi_uart

/* ulsi_peer.sv */
// serial peer model: drives the receive line and samples the transmit line
`timescale 1ns/1ps
module ulsi_peer (
  // clock
  input wire logic core_clk,
  // serial lines
  input wire logic serial_tx_pin,
  output logic serial_rx_pin
);
  initial serial_rx_pin = 1'b1;
  // one bit time is sixteen cycles at divisor one
  task bit_out(input logic b);
    serial_rx_pin <= b;
    repeat (16) @(posedge core_clk);
  endtask : bit_out
  // lsb first, optional parity, then a single stop bit of the given level
  task send(input logic [7:0] d, input int nb, input logic pen, input logic par, input logic stop);
    int i;
    @(posedge core_clk);
    bit_out(1'b0);
    for (i = 0; i < nb; i++) begin
      bit_out(d[i]);
    end
    if (pen) bit_out(par);
    bit_out(stop);
    serial_rx_pin <= 1'b1;
  endtask : send
  // samples on the falling edge so the registered output is settled
  task grab(input int nb, output logic [8:0] b);
    int j;
    b = '0;
    do @(negedge core_clk); while (serial_tx_pin !== 1'b0);
    repeat (8) @(negedge core_clk);
    for (j = 0; j < nb; j++) begin
      repeat (16) @(negedge core_clk);
      b[j] = serial_tx_pin;
    end
  endtask : grab
endmodule : ulsi_peer

/* ulsi_uart_bench.sv */
// self-checking bench for the serial line element over axi4-lite
`timescale 1ns/1ps
module ulsi_uart_bench;
  import ulsi_pkg::*;
  localparam logic [7:0] A_DATA = {3'h0, IDX_DATA, 2'h0};
  localparam logic [7:0] A_IER = {3'h0, IDX_IER, 2'h0};
  localparam logic [7:0] A_IIR = {3'h0, IDX_IIR, 2'h0};
  localparam logic [7:0] A_LCR = {3'h0, IDX_LCR, 2'h0};
  localparam logic [7:0] A_LSR = {3'h0, IDX_LSR, 2'h0};
  localparam logic [7:0] A_MSR = {3'h0, IDX_MSR, 2'h0};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [ULSI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic cts_n = 1'b1, dsr_n = 1'b1, ri_n = 1'b1, dcd_n = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_tx_pin, serial_rx_pin, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic [7:0] rd;
  logic [8:0] got;
  logic par;
  int mismatches = 0, tests_run = 0, nb, k;
  logic [7:0] lcr_tab [5] = '{8'h00, 8'h1B, 8'h0A, 8'h39, 8'h29};
  // each value fits its frame length, so the received byte equals the sent one
  logic [7:0] dat_tab [5] = '{8'h15, 8'hA5, 8'h35, 8'h0C, 8'h13};
  always #10 core_clk = ~core_clk;
  ulsi_uart u_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_rx_pin, .serial_tx_pin,
    .cts_n, .dsr_n, .ri_n, .dcd_n, .irq);
  ulsi_peer u_peer (.core_clk, .serial_tx_pin, .serial_rx_pin);
  task chk(input string what, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // handshakes looked at on the falling edge, so each decision matches the next rising edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, hb;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
  endtask : wr
  task rd_reg(input logic [7:0] a);
    logic ta, hv;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hv = 1'b0;
    while (!hv) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      hv = s_axi_rvalid;
      rd = s_axi_rdata[7:0];
      resp = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (hv) s_axi_rready <= 1'b0;
    end
  endtask : rd_reg
  task rc(input logic [7:0] a, input string what, input logic [7:0] e);
    rd_reg(a);
    chk(what, e, rd);
  endtask : rc
  task rx_case(input logic [7:0] d, input logic pe, input logic p, input logic s, input logic [7:0] el,
    input logic [7:0] ei);
    u_peer.send(d, nb, pe, p, s);
    repeat (4) @(posedge core_clk);
    rc(A_IIR, "iir", ei);
    rc(A_LSR, "lsr", el);
    rc(A_DATA, "rbr", d);
    rc(A_LSR, "lsr_after", 8'h60);
  endtask : rx_case
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rc(A_LSR, "lsr_rst", 8'h60);
    rc(A_IIR, "iir_rst", 8'h01);
    rc(A_LCR, "lcr_rst", 8'h00);
    wr(A_LCR, 8'h80);
    wr(A_DATA, 8'h01);
    wr(A_IER, 8'h00);
    rc(A_DATA, "div_low", 8'h01);
    wr(A_LCR, 8'h03);
    rc(A_IER, "ier_shared", 8'h00);
    wr(A_IER, 8'h02);
    // the identity read below clears the source, so the pin is looked at first
    @(negedge core_clk);
    chk("irq_set", 8'h01, {7'h00, irq});
    rc(A_IIR, "iir_transmit_holding_empty", 8'h02);
    rc(A_IIR, "iir_transmit_holding_empty_clr", 8'h01);
    @(negedge core_clk);
    chk("irq_idle", 8'h00, {7'h00, irq});
    wr(A_IER, 8'h00);
    // every length and parity kind, sent and then received back
    for (k = 0; k < 5; k++) begin
      wr(A_LCR, lcr_tab[k]);
      rc(A_LCR, "lcr_back", lcr_tab[k]);
      nb = 5 + lcr_tab[k][1:0];
      par = lcr_tab[k][5] ? ~lcr_tab[k][4] : (^dat_tab[k] ^ ~lcr_tab[k][4]);
      fork
        wr(A_DATA, dat_tab[k]);
        u_peer.grab(nb + lcr_tab[k][3], got);
      join
      chk("tx_data", dat_tab[k], got[7:0] & ~(8'hFF << nb));
      if (lcr_tab[k][3]) chk("tx_par", {7'h00, par}, {7'h00, got[nb]});
      repeat (60) @(posedge core_clk);
      rx_case(dat_tab[k], lcr_tab[k][3], par, 1'b1, 8'h61, 8'h01);
    end
    wr(A_IER, 8'h05);
    wr(A_LCR, 8'h1B);
    nb = 8;
    u_peer.send(8'h3C, nb, 1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge core_clk);
    rc(A_IIR, "iir_line", 8'h06);
    rc(A_LSR, "lsr_par", 8'h65);
    rc(A_IIR, "iir_after_lsr", 8'h04);
    rc(A_DATA, "rbr_par", 8'h3C);
    rc(A_IIR, "iir_clear", 8'h01);
    wr(A_LCR, 8'h03);
    rx_case(8'h5A, 1'b0, 1'b0, 1'b0, 8'h69, 8'h06);
    rx_case(8'h00, 1'b0, 1'b0, 1'b0, 8'h79, 8'h06);
    // two stop bits set, yet one stop bit between frames is accepted
    wr(A_LCR, 8'h07);
    u_peer.send(8'h11, nb, 1'b0, 1'b0, 1'b1);
    u_peer.send(8'h22, nb, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge core_clk);
    rc(A_LSR, "lsr_ovr", 8'h63);
    rc(A_DATA, "rbr_ovr", 8'h22);
    rc(A_LSR, "lsr_ovr_clr", 8'h60);
    wr(A_LCR, 8'h43);
    @(negedge core_clk);
    chk("brk_pin", 8'h00, {7'h00, serial_tx_pin});
    wr(A_DATA, 8'h55);
    rc(A_LSR, "lsr_brk_busy", 8'h20);
    repeat (200) @(posedge core_clk);
    rc(A_LSR, "lsr_brk_done", 8'h60);
    wr(A_LCR, 8'h03);
    @(negedge core_clk);
    chk("brk_off_pin", 8'h01, {7'h00, serial_tx_pin});
    wr(A_IER, 8'h08);
    cts_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rc(A_IIR, "iir_modem", 8'h00);
    rc(A_MSR, "msr", 8'h11);
    rc(A_IIR, "iir_modem_clr", 8'h01);
    wr(8'h40, 8'h00);
    chk("bresp_unmapped", {6'h00, AXI_SLVERR}, {6'h00, resp});
    rd_reg(8'h40);
    chk("rresp_unmapped", {6'h00, AXI_SLVERR}, {6'h00, resp});
    stop_test;
  end
endmodule : ulsi_uart_bench
